// [hw/subsfr_pkg.sv]
// Package for the subtract and special-page move execution block.
// Assumes an external decoder presents one operation per cycle.
//
// Function
// [RULE_01] Borrow-subtract memory: R plus ~acc plus carry.
// [RULE_02] Borrow-subtract immediate: i plus ~acc plus carry.
// [RULE_03] Plain memory subtract: R minus acc.
// [RULE_04] Destination bit picks accumulator or register.
// [RULE_05] Page store copies accumulator, index 0..21.
// [RULE_06] Page load copies register to accumulator.
// [RULE_07] Carry/digit-carry mean no borrow; zero flag.
package subsfr_pkg;

	// ----------------------------------------
	// Widths and ranges
	// ----------------------------------------
	localparam int DATA_W        = 8;
	localparam int MEM_ADDR_W    = 7;
	localparam int PAGE_ADDR_W   = 5;
	localparam int PAGE_COUNT    = 22;
	localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] PAGE_RESET = 8'h00;
	localparam logic              FLAG_RESET = 1'b0;

	// ----------------------------------------
	// Operations
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NONE,
		OP_SUB_BORROW_MEM,
		OP_SUB_BORROW_IMM,
		OP_SUB_ACC_FROM_MEM,
		OP_SPECIAL_PAGE_STORE,
		OP_SPECIAL_PAGE_LOAD
	} op_type;

	typedef struct packed {
		logic                   valid;
		op_type                 op;
		logic [MEM_ADDR_W-1:0]  mem_addr;
		logic                   dest_reg;
		logic [DATA_W-1:0]      operand;
		logic [PAGE_ADDR_W-1:0] page_index;
	} cmd_type;

	typedef struct packed {
		logic zero;
		logic digit_carry_flag;
		logic carry;
	} flags_type;

	typedef struct packed {
		logic                  write;
		logic [MEM_ADDR_W-1:0] addr;
		logic [DATA_W-1:0]     data;
	} mem_wr_type;

endpackage : subsfr_pkg

// [hw/sub_adder.sv]
// Eight-bit adder with carry in that reports nibble and byte carries.
// Purely combinational; used by the execution block.
`timescale 1ns/1ns
`default_nettype none
module sub_adder (
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       cin,
	output logic      [7:0] sum,
	output logic            carry_nib,
	output logic            carry_out
);
	logic [4:0] low;
	logic [4:0] high;

	always_comb begin
		low       = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		high      = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low[4]};
		sum       = {high[3:0], low[3:0]};
		carry_nib = low[4];
		carry_out = high[4];
	end
endmodule : sub_adder
`default_nettype wire

// [hw/sub_sfr_exec.sv]
// Execution block for subtract and special-page register moves.
// Assumes the decoder supplies the memory operand read in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module sub_sfr_exec #(
	parameter int PAGE_COUNT = subsfr_pkg::PAGE_COUNT
) (
	input  wire logic                                  clk,
	input  wire logic                                  reset_n,
	input  wire subsfr_pkg::cmd_type                   cmd,
	output logic      [subsfr_pkg::DATA_W-1:0]         accumulator,
	output subsfr_pkg::flags_type                      flags,
	output subsfr_pkg::mem_wr_type                     mem_wr,
	output logic      [subsfr_pkg::DATA_W-1:0]         page_data,
	output logic      [subsfr_pkg::PAGE_ADDR_W-1:0]    page_index
);
	// ----------------------------------------
	// Constants
	// ----------------------------------------
	localparam int IDX_W = subsfr_pkg::PAGE_ADDR_W;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [subsfr_pkg::DATA_W-1:0] acc_r;
	logic [subsfr_pkg::DATA_W-1:0] acc_nxt;
	subsfr_pkg::flags_type         flags_r;
	subsfr_pkg::flags_type         flags_nxt;
	subsfr_pkg::mem_wr_type        wr_r;
	subsfr_pkg::mem_wr_type        wr_nxt;
	logic [subsfr_pkg::DATA_W-1:0] page_r   [PAGE_COUNT];
	logic [subsfr_pkg::DATA_W-1:0] page_nxt [PAGE_COUNT];

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic                  is_sbc_mem;
	logic                  is_sbc_imm;
	logic                  is_sub_mem;
	logic                  is_store;
	logic                  is_load;
	logic                  is_mem_op;
	logic                  is_arith;
	logic                  page_ok;
	logic [PAGE_COUNT-1:0] page_hit;

	always_comb begin
		is_sbc_mem = 1'b0;
		is_sbc_imm = 1'b0;
		is_sub_mem = 1'b0;
		is_store   = 1'b0;
		is_load    = 1'b0;
		if (cmd.valid) begin
			unique case (cmd.op)
				subsfr_pkg::OP_SUB_BORROW_MEM: begin
					is_sbc_mem = 1'b1;
				end
				subsfr_pkg::OP_SUB_BORROW_IMM: begin
					is_sbc_imm = 1'b1;
				end
				subsfr_pkg::OP_SUB_ACC_FROM_MEM: begin
					is_sub_mem = 1'b1;
				end
				subsfr_pkg::OP_SPECIAL_PAGE_STORE: begin
					is_store = 1'b1;
				end
				subsfr_pkg::OP_SPECIAL_PAGE_LOAD: begin
					is_load = 1'b1;
				end
				subsfr_pkg::OP_NONE: begin
				end
				default: begin
				end
			endcase
		end
	end

	assign is_mem_op = is_sbc_mem | is_sub_mem;
	assign is_arith  = is_mem_op | is_sbc_imm;
	assign page_ok   = 32'(cmd.page_index) < PAGE_COUNT;

	// ----------------------------------------
	// Subtract datapath
	// ----------------------------------------
	logic [subsfr_pkg::DATA_W-1:0] add_a;
	logic [subsfr_pkg::DATA_W-1:0] add_b;
	logic [subsfr_pkg::DATA_W-1:0] sum;
	logic                          cin;
	logic                          c_nib;
	logic                          c_out;
	logic                          sum_zero;

	always_comb begin
		add_a = cmd.operand; // RULE_01
		add_b = ~acc_r; // RULE_01
		cin   = flags_r.carry; // RULE_02
		if (is_sub_mem) begin
			cin = 1'b1; // RULE_03
		end
	end

	sub_adder u_adder (
		.a         (add_a),
		.b         (add_b),
		.cin       (cin),
		.sum       (sum),
		.carry_nib (c_nib),
		.carry_out (c_out)
	);

	assign sum_zero = (sum == '0); // RULE_07

	// ----------------------------------------
	// Page select
	// ----------------------------------------
	logic [subsfr_pkg::DATA_W-1:0] page_sel;

	always_comb begin
		page_sel = '0;
		for (int i = 0; i < PAGE_COUNT; i++) begin
			if (page_hit[i]) begin
				page_sel = page_r[i];
			end
		end
	end

	// ----------------------------------------
	// Page registers
	// ----------------------------------------
	generate
		for (genvar g = 0; g < PAGE_COUNT; g++) begin : g_page
			assign page_hit[g] = (cmd.page_index == IDX_W'(g));

			always_comb begin
				page_nxt[g] = page_r[g];
				if (is_store && page_ok && page_hit[g]) begin
					page_nxt[g] = acc_r; // RULE_05
				end
			end

			always_ff @(posedge clk) begin
				if (!reset_n) begin
					page_r[g] <= subsfr_pkg::PAGE_RESET;
				end else begin
					page_r[g] <= page_nxt[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Accumulator
	// ----------------------------------------
	always_comb begin
		acc_nxt = acc_r;
		if (is_sbc_imm) begin
			acc_nxt = sum; // RULE_02
		end else if (is_mem_op && !cmd.dest_reg) begin
			acc_nxt = sum; // RULE_04
		end else if (is_load && page_ok) begin
			acc_nxt = page_sel; // RULE_06
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			acc_r <= subsfr_pkg::ACC_RESET;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	always_comb begin
		flags_nxt = flags_r;
		if (is_arith) begin
			flags_nxt.carry            = c_out; // RULE_07
			flags_nxt.digit_carry_flag = c_nib; // RULE_07
			flags_nxt.zero             = sum_zero; // RULE_07
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flags_r.zero             <= subsfr_pkg::FLAG_RESET;
			flags_r.digit_carry_flag <= subsfr_pkg::FLAG_RESET;
			flags_r.carry            <= subsfr_pkg::FLAG_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// ----------------------------------------
	// Write-back
	// ----------------------------------------
	always_comb begin
		wr_nxt = '0;
		if (is_mem_op && cmd.dest_reg) begin
			wr_nxt.write = 1'b1; // RULE_04
			wr_nxt.addr  = cmd.mem_addr; // RULE_04
			wr_nxt.data  = sum; // RULE_04
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_r <= '0;
		end else begin
			wr_r <= wr_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign accumulator = acc_r;
	assign flags       = flags_r;
	assign mem_wr      = wr_r;
	assign page_index  = cmd.page_index;
	assign page_data   = page_ok ? page_sel : '0;

endmodule : sub_sfr_exec
`default_nettype wire

// [testbench/sub_sfr_exec_assertions.sv]
// Checker for the subtract and page-move block.
// Assumes it is bound onto sub_sfr_exec.
`timescale 1ns/1ns
`default_nettype none
module sub_sfr_exec_assertions (
	input wire logic                   clk,
	input wire logic                   reset_n,
	input wire subsfr_pkg::cmd_type    cmd,
	input wire logic [7:0]             accumulator,
	input wire subsfr_pkg::flags_type  flags,
	input wire subsfr_pkg::mem_wr_type mem_wr,
	input wire logic [7:0]             page_data,
	input wire logic [4:0]             page_index
);
	logic       ci;
	logic [8:0] s;
	logic [4:0] n;
	logic       sb;
	always_comb begin
		ci = (cmd.op == subsfr_pkg::OP_SUB_ACC_FROM_MEM) ? 1'b1 : flags.carry;
		s = {1'b0, cmd.operand} + {1'b0, ~accumulator} + 9'(ci);
		n = {1'b0, cmd.operand[3:0]} + {1'b0, ~accumulator[3:0]} + 5'(ci);
		sb = cmd.valid && cmd.op inside {3'h1, 3'h2, 3'h3};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_sbc_mem_acc: assert property (cmd.valid && cmd.op == 3'h1 && !cmd.dest_reg
		|=> accumulator == $past(s[7:0])) else $error("Borrow subtract result wrong.");
	a_sbc_imm_acc: assert property (cmd.valid && cmd.op == 3'h2
		|=> accumulator == $past(s[7:0])) else $error("Immediate subtract wrong.");
	a_sub_write_back: assert property (cmd.valid && cmd.op == 3'h3 && cmd.dest_reg
		|=> mem_wr.write && mem_wr.data == $past(s[7:0]) && mem_wr.addr == $past(cmd.mem_addr))
		else $error("Plain subtract write wrong.");
	a_dest_select: assert property (sb && cmd.op != 3'h2
		|=> mem_wr.write == $past(cmd.dest_reg)) else $error("Destination wrong.");
	a_flag_math: assert property (sb
		|=> flags == $past({s[7:0] == 8'h00, n[4], s[8]})) else $error("Flags wrong.");
	a_store_keeps: assert property (cmd.valid && cmd.op == 3'h4
		|=> $stable(flags) && $stable(accumulator)) else $error("Store changed state.");
	a_load_copy: assert property (cmd.valid && cmd.op == 3'h5 && cmd.page_index < 5'h16
		|=> accumulator == $past(page_data) && $stable(flags)) else $error("Load wrong.");
	a_index_echo: assert property (page_index == cmd.page_index)
		else $error("Page index echo wrong.");
	a_store_lands: assert property (cmd.valid && cmd.op == 3'h4 && page_index < 5'h16
		##1 page_index == $past(page_index) |-> page_data == $past(accumulator))
		else $error("Store did not land.");
endmodule : sub_sfr_exec_assertions
bind sub_sfr_exec sub_sfr_exec_assertions u_chk (.clk(clk), .reset_n(reset_n), .cmd(cmd),
	.accumulator(accumulator), .flags(flags), .mem_wr(mem_wr), .page_data(page_data),
	.page_index(page_index));
`default_nettype wire

// [testbench/sub_sfr_exec_tb.sv]
// Self-checking bench for the subtract and page-move block.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module sub_sfr_exec_tb;
	logic                   clk = 1'b0;
	logic                   reset_n = 1'b0;
	subsfr_pkg::cmd_type    cmd = '0;
	logic [7:0]             accumulator;
	subsfr_pkg::flags_type  flags;
	subsfr_pkg::mem_wr_type mem_wr;
	logic [7:0]             page_data;
	logic [4:0]             page_index;
	int                     errors = 0;
	int                     compares = 0;
	always #25 clk = ~clk;
	sub_sfr_exec DUT (.clk(clk), .reset_n(reset_n), .cmd(cmd), .accumulator(accumulator),
		.flags(flags), .mem_wr(mem_wr), .page_data(page_data), .page_index(page_index));
	task automatic chk(input logic [14:0] g, input logic [14:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic step(input subsfr_pkg::op_type o, input logic d, input logic [7:0] v,
		input logic [4:0] i, input logic [7:0] ea, input logic [2:0] f, input logic [7:0] r);
		@(posedge clk) cmd <= '{1'b1, o, 7'h7F, d, v, i};
		@(posedge clk) cmd.valid <= 1'b0;
		#1 chk({mem_wr.write, flags, accumulator}, {d, f, ea});
		if (d) chk({mem_wr.addr, mem_wr.data}, {7'h7F, r});
	endtask : step
	task automatic t_imm;
		step(subsfr_pkg::OP_SUB_BORROW_IMM, 0, 8'h07, 0, 8'h06, 3'h3, 0);
	endtask : t_imm
	task automatic t_sbc;
		step(subsfr_pkg::OP_SUB_BORROW_MEM, 1, 8'h05, 0, 8'h06, 3'h0, 8'hFF);
		step(subsfr_pkg::OP_SUB_BORROW_MEM, 1, 8'h05, 0, 8'h06, 3'h0, 8'hFE);
		step(subsfr_pkg::OP_SUB_BORROW_MEM, 0, 8'h06, 0, 8'hFF, 3'h0, 0);
	endtask : t_sbc
	task automatic t_sub;
		step(subsfr_pkg::OP_SUB_ACC_FROM_MEM, 0, 8'hFF, 0, 8'h00, 3'h7, 0);
		step(subsfr_pkg::OP_SUB_ACC_FROM_MEM, 1, 8'h05, 0, 8'h00, 3'h3, 8'h05);
	endtask : t_sub
	task automatic t_page;
		step(subsfr_pkg::OP_SUB_BORROW_IMM, 0, 8'h06, 0, 8'h06, 3'h3, 0);
		step(subsfr_pkg::OP_SPECIAL_PAGE_STORE, 0, 0, 21, 8'h06, 3'h3, 0);
		chk({page_index, page_data}, {5'h15, 8'h06});
		step(subsfr_pkg::OP_SUB_BORROW_IMM, 0, 8'h0A, 0, 8'h04, 3'h3, 0);
		step(subsfr_pkg::OP_SPECIAL_PAGE_LOAD, 0, 0, 21, 8'h06, 3'h3, 0);
		step(subsfr_pkg::OP_SPECIAL_PAGE_STORE, 0, 0, 22, 8'h06, 3'h3, 0);
		chk({page_index, page_data}, {5'h16, 8'h00});
		step(subsfr_pkg::OP_SPECIAL_PAGE_LOAD, 0, 0, 22, 8'h06, 3'h3, 0);
		step(subsfr_pkg::OP_SPECIAL_PAGE_LOAD, 0, 0, 0, 8'h00, 3'h3, 0);
	endtask : t_page
	task automatic t_reset;
		@(posedge clk) reset_n <= 1'b0;
		@(posedge clk) reset_n <= 1'b1;
		#1 chk({mem_wr.write, flags, accumulator}, 12'h000);
		step(subsfr_pkg::OP_SPECIAL_PAGE_LOAD, 0, 0, 21, 8'h00, 3'h0, 0);
	endtask : t_reset
	task automatic results;
		$display("Compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		t_imm();
		t_sbc();
		t_sub();
		t_page();
		t_reset();
		results();
	end
	initial begin
		#20000;
		errors++;
		results();
	end
endmodule : sub_sfr_exec_tb
`default_nettype wire
